// ---- include/ttm_pkg.sv ----
// package: register map, field layout and timing constants of the thermal threshold monitor
package ttm_pkg;

    // ****************************************************************
    // dimensions
    // ****************************************************************
    localparam int NUM_LEVELS = 6;
    localparam int ADDR_W     = 4;
    localparam int DATA_W     = 32;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFF_CTRL      = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_SENSE     = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_IRQ_FLAG  = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 4'hC;

    // ****************************************************************
    // field positions of the control register
    // ****************************************************************
    localparam int CTRL_MON_EN_BIT   = 0;
    localparam int CTRL_AON_BIT      = 1;
    localparam int CTRL_STANDBY_BIT  = 2;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [2:0]            CTRL_RESET = 3'h1;
    localparam logic [NUM_LEVELS-1:0] MASK_RESET = 6'h3F;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_HZ           = 20_000_000;
    localparam int DEBOUNCE_NS      = 10_000;
    localparam int WINDOW_US        = 450;
    localparam int INTERVAL_US      = 3_000;
    localparam int DEBOUNCE_CYCLES  = DEBOUNCE_NS / 50;
    localparam int WINDOW_CYCLES    = WINDOW_US * (CLK_HZ / 1_000_000);
    localparam int INTERVAL_CYCLES  = INTERVAL_US * (CLK_HZ / 1_000_000);
    localparam int DB_W             = 8;
    localparam int SAMP_W           = 16;

    // ****************************************************************
    // bus carrier
    // ****************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ttm_bus_req_t;

    typedef enum logic [1:0] {
        SAMP_OFF  = 2'b00,
        SAMP_ON   = 2'b01,
        SAMP_IDLE = 2'b11
    } ttm_samp_state_t;

endpackage : ttm_pkg

// ---- hw/ttm_debounce.sv ----
// one debounced comparator channel with two-flop input synchroniser
`timescale 1ns/1ps
module ttm_debounce
    import ttm_pkg::*;
(
    input  wire logic clk_in,    // system clock
    input  wire logic rst_in,    // async reset, active high
    input  wire logic ce_in,     // clock enable
    input  wire logic active_in, // monitor powered and sampling
    input  wire logic raw_in,    // raw comparator output from pin
    output logic      level_out  // debounced level
);
    logic            sync1_reg, sync2_reg, sync1_next, sync2_next;
    logic            level_reg, level_next;
    logic [DB_W-1:0] cnt_reg, cnt_next;

    always_comb begin
        sync1_next = raw_in;
        sync2_next = sync1_reg;
        level_next = level_reg;
        cnt_next   = '0;
        // hold the level while powered down so no stale event appears
        if (active_in && sync2_reg != level_reg) begin
            if (cnt_reg == DB_W'(DEBOUNCE_CYCLES - 1)) begin
                level_next = sync2_reg;
            end else begin
                cnt_next = cnt_reg + DB_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            level_reg <= 1'b0;
            cnt_reg   <= '0;
        end else if (ce_in) begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            level_reg <= level_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign level_out = level_reg;

endmodule : ttm_debounce

// ---- hw/ttm_sampler.sv ----
// duty-cycle scheduler that powers the monitor for a window each interval
`timescale 1ns/1ps
module ttm_sampler
    import ttm_pkg::*;
(
    input  wire logic clk_in,     // system clock
    input  wire logic rst_in,     // async reset, active high
    input  wire logic ce_in,      // clock enable
    input  wire logic enable_in,  // monitor enable
    input  wire logic aon_in,     // continuous mode wanted
    output logic      power_out   // monitor analog power
);
    ttm_samp_state_t   st_reg, st_next;
    logic [SAMP_W-1:0] cnt_reg, cnt_next;

    always_comb begin
        st_next  = st_reg;
        cnt_next = cnt_reg + SAMP_W'(1);
        unique case (st_reg)
            SAMP_OFF: begin
                cnt_next = '0;
                if (enable_in) st_next = SAMP_ON;
            end
            SAMP_ON: begin
                if (!enable_in) begin
                    st_next = SAMP_OFF;
                end else if (aon_in) begin
                    cnt_next = '0;
                end else if (cnt_reg == SAMP_W'(WINDOW_CYCLES - 1)) begin
                    st_next = SAMP_IDLE;
                end
            end
            SAMP_IDLE: begin
                if (!enable_in) begin
                    st_next = SAMP_OFF;
                end else if (aon_in || cnt_reg == SAMP_W'(INTERVAL_CYCLES - 1)) begin
                    st_next  = SAMP_ON;
                    cnt_next = '0;
                end
            end
            default: begin
                st_next  = SAMP_OFF;
                cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg  <= SAMP_OFF;
            cnt_reg <= '0;
        end else if (ce_in) begin
            st_reg  <= st_next;
            cnt_reg <= cnt_next;
        end
    end

    assign power_out = (st_reg == SAMP_ON);

endmodule : ttm_sampler

// ---- hw/ttm_top.sv ----
// thermal threshold monitor: debounced warnings, flags, shutdown and register port
//
// Behaviour
// [R1] six warning levels, each with latched flag, live sense and mask bit
// [R2] a rising crossing of a warning threshold sets that level's flag
// [R3] sense releases only below the falling comparator, 5 C under threshold
// [R4] shutdown starts above 165 C and blocks restart until its release comparator
// [R5] only the die-centre comparators feed warnings and shutdown
// [R6] monitor enable bit powers monitoring on or off, written by software
// [R7] run state with always-on set keeps the monitor continuously powered
// [R8] always-on clear samples: 450 us window every 3.0 ms
// [R9] standby always samples, and only while monitoring is enabled
// [R10] each comparison is debounced 10 us in both directions
// [R11] unmasked set flag drives interrupt low; write one clears; sense is live
// [R12] disabled or between windows, sense holds and no new events arise
`timescale 1ns/1ps
module ttm_top
    import ttm_pkg::*;
(
    input  wire logic                  clk_in,        // 20 MHz clock
    input  wire logic                  rst_in,        // async reset, active high
    input  wire logic                  ce_in,         // clock enable, freezes all state
    input  wire logic [ADDR_W-1:0]     addr_in,       // register byte address
    input  wire logic [DATA_W-1:0]     wdata_in,      // write data
    input  wire logic                  wr_in,         // write strobe
    input  wire logic                  rd_in,         // read strobe
    output logic      [DATA_W-1:0]     rdata_out,     // read data, cycle after strobe
    input  wire logic [NUM_LEVELS-1:0] warn_rise_in,  // centre sensor above threshold
    input  wire logic [NUM_LEVELS-1:0] warn_fall_in,  // centre sensor above threshold-5C
    input  wire logic                  sd_trip_in,    // centre sensor above shutdown level
    input  wire logic                  sd_clear_in,   // centre sensor above shutdown release
    output logic                       mon_power_out, // analog monitor power
    output logic                       shutdown_out,  // thermal shutdown request
    output logic                       interrupt_out_n // interrupt, active low
);
    // ****************************************************************
    // registers
    // ****************************************************************
    ttm_bus_req_t          req;
    logic [2:0]            ctrl_reg, ctrl_next;
    logic [NUM_LEVELS-1:0] mask_reg, mask_next;
    logic [NUM_LEVELS-1:0] flag_reg, flag_next;
    logic [NUM_LEVELS-1:0] sense_prev_reg, sense_prev_next;
    logic                  sd_reg, sd_next;
    logic [DATA_W-1:0]     rdata_reg, rdata_next;
    logic [NUM_LEVELS-1:0] hi_lvl, lo_lvl, sense;
    logic                  sd_hi, sd_lo, active, monitor_enable, always_on_select;
    logic                  standby, samp_power;

    assign req              = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
    assign monitor_enable   = ctrl_reg[CTRL_MON_EN_BIT];                     // [R6]
    assign always_on_select = ctrl_reg[CTRL_AON_BIT];
    assign standby          = ctrl_reg[CTRL_STANDBY_BIT];

    // ****************************************************************
    // power scheduling
    // ****************************************************************
    ttm_sampler u_sampler (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .enable_in (monitor_enable),                                         // [R6]
        .aon_in    (always_on_select && !standby),                           // [R7] [R9]
        .power_out (samp_power)                                              // [R8]
    );
    assign active        = samp_power;
    assign mon_power_out = samp_power;

    // ****************************************************************
    // comparator debounce, centre sensor only
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_LEVELS + 1; g++) begin : g_ch
            logic rise_raw, fall_raw, hi_out, lo_out;
            assign rise_raw = (g < NUM_LEVELS) ? warn_rise_in[g % NUM_LEVELS] : sd_trip_in;
            assign fall_raw = (g < NUM_LEVELS) ? warn_fall_in[g % NUM_LEVELS] : sd_clear_in;
            ttm_debounce u_hi (                                              // [R10] [R5]
                .clk_in    (clk_in),
                .rst_in    (rst_in),
                .ce_in     (ce_in),
                .active_in (active),                                         // [R12]
                .raw_in    (rise_raw),
                .level_out (hi_out)
            );
            ttm_debounce u_lo (                                              // [R10]
                .clk_in    (clk_in),
                .rst_in    (rst_in),
                .ce_in     (ce_in),
                .active_in (active),
                .raw_in    (fall_raw),
                .level_out (lo_out)
            );
            if (g < NUM_LEVELS) begin : g_w
                assign hi_lvl[g] = hi_out;
                assign lo_lvl[g] = lo_out;
            end else begin : g_s
                assign sd_hi = hi_out;
                assign sd_lo = lo_out;
            end
        end
    endgenerate

    // ****************************************************************
    // sense, flags, shutdown and register port
    // ****************************************************************
    always_comb begin
        ctrl_next       = ctrl_reg;
        mask_next       = mask_reg;
        rdata_next      = '0;
        // sense sets on the upper comparator, releases only below the lower one
        sense_prev_next = (sense_prev_reg & lo_lvl) | hi_lvl;               // [R3]
        sense           = sense_prev_reg;
        flag_next       = flag_reg;
        if (req.wr && req.addr == OFF_IRQ_FLAG) begin
            flag_next = flag_reg & ~req.wdata[NUM_LEVELS-1:0];              // [R11]
        end
        // set beats a same-cycle clear
        flag_next = flag_next | (hi_lvl & ~sense_prev_reg);                 // [R2] [R1]
        // latched until the release comparator drops; blocks restart meanwhile
        sd_next = sd_hi | (sd_reg & sd_lo);                                  // [R4]
        if (req.wr) begin
            unique case (req.addr)
                OFF_CTRL:     ctrl_next = req.wdata[2:0];                    // [R6]
                OFF_IRQ_MASK: mask_next = req.wdata[NUM_LEVELS-1:0];
                default:      ctrl_next = ctrl_reg;
            endcase
        end
        if (req.rd) begin
            unique case (req.addr)
                OFF_CTRL:     rdata_next = {29'h0, ctrl_reg};
                OFF_SENSE:    rdata_next = {25'h0, sd_reg, sense};           // [R11]
                OFF_IRQ_FLAG: rdata_next = {26'h0, flag_reg};
                OFF_IRQ_MASK: rdata_next = {26'h0, mask_reg};
                default:      rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_reg       <= CTRL_RESET;
            mask_reg       <= MASK_RESET;
            flag_reg       <= '0;
            sense_prev_reg <= '0;
            sd_reg         <= 1'b0;
            rdata_reg      <= '0;
        end else if (ce_in) begin
            ctrl_reg       <= ctrl_next;
            mask_reg       <= mask_next;
            flag_reg       <= flag_next;
            sense_prev_reg <= sense_prev_next;
            sd_reg         <= sd_next;
            rdata_reg      <= rdata_next;
        end
    end

    assign rdata_out       = rdata_reg;
    assign shutdown_out    = sd_reg;
    assign interrupt_out_n = ~|(flag_reg & ~mask_reg);                       // [R11]

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_irq_level: assert property (interrupt_out_n == !(|(flag_reg & ~mask_reg))) // [R11]
        else $error("interrupt level does not follow flags and mask");
    chk_flag_set: assert property (ce_in && |(hi_lvl & ~sense_prev_reg)     // [R2]
        |=> |flag_reg) else $error("crossing did not set a flag");
    chk_flag_clear: assert property (ce_in && wr_in && addr_in == OFF_IRQ_FLAG
        && wdata_in[0] && !hi_lvl[0] |=> !flag_reg[0]) // [R11]
        else $error("write one did not clear flag");
    chk_sense_hold: assert property (ce_in && sense_prev_reg[0] && lo_lvl[0] // [R3]
        |=> sense_prev_reg[0]) else $error("sense released above lower level");
    chk_sd_latch: assert property (ce_in && sd_hi |=> shutdown_out) // [R4]
        else $error("shutdown not started");
    chk_sd_hold: assert property (shutdown_out && sd_lo && ce_in |=> shutdown_out) // [R4]
        else $error("shutdown released early");
    chk_disable_off: assert property (!monitor_enable ##1 !monitor_enable
        |-> !mon_power_out) // [R6]
        else $error("monitor powered while disabled");
    chk_aon_power: assert property (monitor_enable && always_on_select && !standby
        && mon_power_out && ce_in |=> mon_power_out) // [R7]
        else $error("always-on mode dropped power");
    chk_hold_idle: assert property (!active && ce_in |=> $stable(hi_lvl)) // [R12]
        else $error("sense moved while idle");
    chk_ctrl_write: assert property (ce_in && wr_in && addr_in == OFF_CTRL
        |=> ctrl_reg == $past(wdata_in[2:0])) // [R6]
        else $error("control write lost");

    cov_flag_set:  cover property (|flag_reg ##1 !interrupt_out_n);
    cov_shutdown:  cover property ($rose(shutdown_out));
    cov_sampling:  cover property ($fell(mon_power_out) && monitor_enable);

endmodule : ttm_top

// ---- test/ttm_top_tb.sv ----
// self-checking testbench of the thermal threshold monitor register port and flags
`timescale 1ns/1ps
module ttm_top_tb;
    import ttm_pkg::*;

    // ****************************************************************
    // signals and instance
    // ****************************************************************
    logic                  clk_in;
    logic                  rst_in;
    logic                  ce_in;
    logic [ADDR_W-1:0]     addr_in;
    logic [DATA_W-1:0]     wdata_in;
    logic                  wr_in;
    logic                  rd_in;
    logic [DATA_W-1:0]     rdata_out;
    logic [NUM_LEVELS-1:0] warn_rise_in;
    logic [NUM_LEVELS-1:0] warn_fall_in;
    logic                  sd_trip_in;
    logic                  sd_clear_in;
    logic                  mon_power_out;
    logic                  shutdown_out;
    logic                  interrupt_out_n;
    logic [DATA_W-1:0]     rd_val;
    int                    n_fail;
    int                    n_checks;
    int                    cnt;
    // raw input to sense needs 2 sync + 200 debounce + 1 cycles; 215 leaves margin
    localparam int SETTLE = 215;

    ttm_top ttm_top_i (
        .clk_in          (clk_in),
        .rst_in          (rst_in),
        .ce_in           (ce_in),
        .addr_in         (addr_in),
        .wdata_in        (wdata_in),
        .wr_in           (wr_in),
        .rd_in           (rd_in),
        .rdata_out       (rdata_out),
        .warn_rise_in    (warn_rise_in),
        .warn_fall_in    (warn_fall_in),
        .sd_trip_in      (sd_trip_in),
        .sd_clear_in     (sd_clear_in),
        .mon_power_out   (mon_power_out),
        .shutdown_out    (shutdown_out),
        .interrupt_out_n (interrupt_out_n)
    );

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic end_of_test;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_word(input string name, input logic [DATA_W-1:0] exp,
                            input logic [DATA_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : wait_cyc

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic reg_chk(input string name, input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1;
        rd_val = rdata_out;
        chk_word(name, exp, rd_val);
    endtask : reg_chk

    // ****************************************************************
    // watchdog
    // ****************************************************************
    initial begin
        wait_cyc(100_000);
        n_fail++;
        end_of_test();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        n_fail       = 0;
        n_checks     = 0;
        rst_in       = 1'b1;
        ce_in        = 1'b1;
        addr_in      = 4'h0;
        wdata_in     = 32'h0;
        wr_in        = 1'b0;
        rd_in        = 1'b0;
        warn_rise_in = 6'h00;
        warn_fall_in = 6'h00;
        sd_trip_in   = 1'b0;
        sd_clear_in  = 1'b0;
        wait_cyc(12);
        rst_in <= 1'b0;
        reg_chk("ctrl reset", OFF_CTRL, 32'(CTRL_RESET));
        reg_chk("mask reset", OFF_IRQ_MASK, 32'(MASK_RESET));
        reg_chk("flag reset", OFF_IRQ_FLAG, 32'h0);
        reg_chk("unmapped", 4'h2, 32'h0);
        chk_bit("irq idle", 1'b1, interrupt_out_n);
        reg_wr(OFF_CTRL, 32'h3);
        // levels one by one: sense holds off until the debounce has run out
        for (int i = 0; i < NUM_LEVELS; i++) begin
            warn_fall_in[i] <= 1'b1;
            warn_rise_in[i] <= 1'b1;
            wait_cyc(150);
            reg_chk("sense early", OFF_SENSE, 32'((1 << i) - 1));
            wait_cyc(60);
            reg_chk("sense set", OFF_SENSE, 32'((2 << i) - 1));
            reg_chk("flag set", OFF_IRQ_FLAG, 32'((2 << i) - 1));
        end
        chk_bit("irq masked", 1'b1, interrupt_out_n);
        // upper comparators drop, lower ones still high: sense must hold
        warn_rise_in <= 6'h00;
        wait_cyc(SETTLE);
        reg_chk("sense hyst", OFF_SENSE, 32'h3F);
        warn_fall_in <= 6'h00;
        wait_cyc(SETTLE);
        reg_chk("sense fall", OFF_SENSE, 32'h0);
        reg_chk("flag sticky", OFF_IRQ_FLAG, 32'h3F);
        reg_wr(OFF_IRQ_MASK, 32'h3E);
        wait_cyc(1);
        chk_bit("irq unmasked", 1'b0, interrupt_out_n);
        reg_wr(OFF_IRQ_FLAG, 32'h01);
        wait_cyc(1);
        chk_bit("irq cleared", 1'b1, interrupt_out_n);
        reg_chk("flag w1c", OFF_IRQ_FLAG, 32'h3E);
        // clock enable low drops the strobe, so the mask must survive
        ce_in <= 1'b0;
        reg_wr(OFF_IRQ_MASK, 32'h0);
        ce_in <= 1'b1;
        reg_chk("mask frozen", OFF_IRQ_MASK, 32'h3E);
        reg_wr(OFF_IRQ_FLAG, 32'h3E);
        reg_wr(OFF_SENSE, 32'hFFFF_FFFF);
        reg_chk("flag clear", OFF_IRQ_FLAG, 32'h0);
        reg_chk("sense ro", OFF_SENSE, 32'h0);
        // shutdown trips, then holds until its release comparator drops too
        sd_clear_in <= 1'b1;
        sd_trip_in  <= 1'b1;
        wait_cyc(SETTLE);
        chk_bit("shutdown on", 1'b1, shutdown_out);
        reg_chk("sense sd", OFF_SENSE, 32'h40);
        sd_trip_in <= 1'b0;
        wait_cyc(SETTLE);
        chk_bit("shutdown held", 1'b1, shutdown_out);
        sd_clear_in <= 1'b0;
        wait_cyc(SETTLE);
        chk_bit("shutdown off", 1'b0, shutdown_out);
        // always-on must outlast a full sampling window
        wait_cyc(WINDOW_CYCLES + 500);
        chk_bit("power aon", 1'b1, mon_power_out);
        reg_wr(OFF_CTRL, 32'h0);
        wait_cyc(2);
        chk_bit("power off", 1'b0, mon_power_out);
        warn_fall_in[5] <= 1'b1;
        warn_rise_in[5] <= 1'b1;
        wait_cyc(SETTLE);
        reg_chk("sense frozen", OFF_SENSE, 32'h0);
        reg_chk("flag frozen", OFF_IRQ_FLAG, 32'h0);
        // standby with always-on set still samples
        reg_wr(OFF_CTRL, 32'h7);
        wait_cyc(SETTLE);
        reg_chk("sense standby", OFF_SENSE, 32'h20);
        reg_chk("flag standby", OFF_IRQ_FLAG, 32'h20);
        // over one full interval the power is high for exactly one window
        cnt = 0;
        repeat (INTERVAL_CYCLES) begin
            @(posedge clk_in);
            #1;
            if (mon_power_out === 1'b1) begin
                cnt++;
            end
        end
        chk_word("window cycles", 32'(WINDOW_CYCLES), 32'(cnt));
        end_of_test();
    end

endmodule : ttm_top_tb
